// ==== design/csc_regs.sv ====
// Purpose: status, processor switch and system switch register banks
// Assumes: one core's banks plus the shared system switch, one clock
// Notes: local requests come from the test port; messages are remote
`timescale 1ns/1ps
`default_nettype none
module csc_regs
  import csc_pkg::*;
#(
  parameter int NTHREAD = 8,
  parameter int NSCR = 8,
  parameter int NLINK = 16,
  parameter logic [7:0] CORE_VER = 8'h01,
  parameter logic [7:0] CORE_REV = 8'h00,
  parameter logic [1:0] CORE_NUM = 2'h0,
  parameter logic [31:0] CORE_RES1 = 32'h20040808,
  parameter logic [31:0] CORE_RES2 = 32'h00000606,
  parameter logic [7:0] SW_VER = 8'h01,
  parameter logic [7:0] SW_REV = 8'h00,
  parameter logic [31:0] SW_RES = 32'h00100404
) (
  input wire logic CLK,
  input wire logic RSTN,
  // Local (test port) register port
  input wire csc_req_t LOC_REQ,
  output logic [31:0] LOC_RDATA,
  output logic LOC_ACK,
  // Processor instruction status port
  input wire logic PS_VALID,
  input wire logic PS_WR,
  input wire logic [31:0] PS_RESID,
  input wire logic [31:0] PS_WDATA,
  output logic [31:0] PS_RDATA,
  // Interconnect message bytes
  input wire csc_tok_t MSG_IN,
  input wire logic MSG_IN_VALID,
  output csc_tok_t MSG_OUT,
  output logic MSG_OUT_VALID,
  input wire logic MSG_OUT_READY,
  input wire logic MSG_BANK_SS,
  // Core state to mirror
  input wire logic [NTHREAD*32-1:0] THREAD_PC,
  input wire logic [NTHREAD*32-1:0] THREAD_SR,
  input wire logic [4*32-1:0] PLINK_STAT,
  input wire logic [32*32-1:0] LOGICAL_LINK_STAT,
  input wire logic [31:0] SEC_CFG,
  input wire logic [7:0] BOOT_CTRL,
  input wire logic [1:0] CORE_CFG,
  // Control outputs
  output logic DBG_IRQ,
  output logic SLOW_MODE,
  output logic PROC_WR_DIS,
  output logic SHORT_HDR,
  output logic [31:0] RAM_BASE,
  output logic [31:0] VEC_BASE,
  output logic [31:0] PLL_CTRL,
  output logic [7:0] NODE_IDENTIFIER,
  output logic [7:0] SW_DIV,
  output logic [7:0] REF_DIV,
  output logic [NLINK*32-1:0] EXT_CFG,
  output logic [NLINK*32-1:0] INT_CFG,
  output logic [NLINK*32-1:0] SPD_CFG
);

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_RET = 3'b001,
    M_ADDR = 3'b011,
    M_DATA = 3'b010,
    M_EOM = 3'b110,
    M_ACK = 3'b111,
    M_END = 3'b101
  } csc_mst_t;

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic in_blk(input logic [7:0] a,
      input logic [7:0] base, input int n);
    in_blk = (a >= base) && ({24'h0, a} < {24'h0, base} + 32'(n));
  endfunction

  // ****************************************************
  // Message receiver
  // ****************************************************
  csc_mst_t mst_r;
  logic [1:0] cnt_r;
  logic [15:0] maddr_r;
  logic [31:0] mdata_r;
  logic mss_r;
  csc_req_t mreq;

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      mst_r <= M_IDLE;
      cnt_r <= 2'h0;
      maddr_r <= 16'h0000;
      mdata_r <= 32'h00000000;
      mss_r <= 1'b0;
    end else begin
      case (mst_r)
        M_IDLE: begin
          if (MSG_IN_VALID && MSG_IN.ctrl && MSG_IN.data == TOK_CONFIG_WRITE_TOKEN) begin
            mst_r <= M_RET;
            cnt_r <= 2'h0;
            mss_r <= MSG_BANK_SS;
          end
        end
        M_RET: begin
          if (MSG_IN_VALID) begin
            cnt_r <= cnt_r + 2'h1;
            if (cnt_r == 2'h2) begin
              mst_r <= M_ADDR;
              cnt_r <= 2'h0;
            end
          end
        end
        M_ADDR: begin
          if (MSG_IN_VALID) begin
            maddr_r <= {maddr_r[7:0], MSG_IN.data};
            cnt_r <= cnt_r + 2'h1;
            if (cnt_r == 2'h1) begin
              mst_r <= M_DATA;
              cnt_r <= 2'h0;
            end
          end
        end
        M_DATA: begin
          if (MSG_IN_VALID) begin
            mdata_r <= {mdata_r[23:0], MSG_IN.data};
            cnt_r <= cnt_r + 2'h1;
            if (cnt_r == 2'h3) begin
              mst_r <= M_EOM;
            end
          end
        end
        M_EOM: begin
          if (MSG_IN_VALID) begin
            mst_r <= (MSG_IN.ctrl && MSG_IN.data == TOK_EOM) ? M_ACK : M_IDLE;
          end
        end
        M_ACK: begin
          if (MSG_OUT_READY) begin
            mst_r <= M_END;
          end
        end
        M_END: begin
          if (MSG_OUT_READY) begin
            mst_r <= M_IDLE;
          end
        end
        default: mst_r <= M_IDLE;
      endcase
    end
  end

  // Commit a write once the whole message is in
  always_comb begin
    mreq.valid = (mst_r == M_EOM) && MSG_IN_VALID && MSG_IN.ctrl
      && MSG_IN.data == TOK_EOM && maddr_r[15:8] == 8'h00;
    mreq.wr = 1'b1;
    mreq.remote = 1'b1;
    mreq.bank = mss_r ? BANK_SS : BANK_PW;
    mreq.addr = maddr_r[7:0];
    mreq.wdata = mdata_r;
  end

  always_comb begin
    MSG_OUT_VALID = (mst_r == M_ACK) || (mst_r == M_END);
    MSG_OUT.ctrl = 1'b1;
    MSG_OUT.data = (mst_r == M_ACK) ? TOK_ACK : TOK_EOM;
  end

  // Local requests win; a colliding message write is lost
  csc_req_t req;
  always_comb begin
    req = LOC_REQ.valid ? LOC_REQ : mreq;
  end

  // ****************************************************
  // Processor status bank
  // ****************************************************
  logic [31:0] ram_base_r;
  logic [31:0] vec_base_r;
  logic ps_hit;
  assign ps_hit = PS_RESID[7:0] == PS_RES_TYPE;

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ram_base_r <= RAM_BASE_ADDRESS_RST;
      vec_base_r <= 32'h00000000;
    end else if (PS_VALID && PS_WR && ps_hit) begin
      if (PS_RESID[15:8] == RAM_BASE_ADDRESS_OFS) begin
        ram_base_r <= PS_WDATA;
      end else if (PS_RESID[15:8] == PS_VEC_BASE_OFS) begin
        vec_base_r <= PS_WDATA & PS_VEC_MASK;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      PS_RDATA <= 32'h00000000;
    end else if (PS_VALID && ps_hit && PS_RESID[15:8] == RAM_BASE_ADDRESS_OFS) begin
      PS_RDATA <= ram_base_r;
    end else if (PS_VALID && ps_hit && PS_RESID[15:8] == PS_VEC_BASE_OFS) begin
      PS_RDATA <= vec_base_r;
    end else begin
      PS_RDATA <= 32'h00000000;
    end
  end

  // ****************************************************
  // Processor switch bank
  // ****************************************************
  logic [31:0] perm_r;
  logic slow_r;
  logic dbg_irq_r;
  logic [31:0] scr_r [NSCR];
  logic pw_wr;
  logic pw_ok;

  // Remote blocked by bit 8; all locked by bit 31
  assign pw_ok = !perm_r[PERM_LOCK_BIT]
    && !(req.remote && perm_r[PERM_REMDIS_BIT]);
  assign pw_wr = req.valid && req.wr && req.bank == BANK_PW && pw_ok;

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      perm_r <= 32'h00000000;
    end else if (pw_wr && req.addr == PW_PERM_OFS) begin
      perm_r <= req.wdata & PERM_MASK;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      slow_r <= 1'b0;
    end else if (pw_wr && req.addr == PW_CLK_OFS) begin
      slow_r <= req.wdata[SLOW_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      dbg_irq_r <= 1'b0;
    end else begin
      dbg_irq_r <= pw_wr && req.addr == PW_DBGINT_OFS
        && req.wdata[DBGINT_BIT];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NSCR; gi++) begin : g_scr
      always_ff @(posedge CLK) begin
        if (!RSTN) begin
          scr_r[gi] <= 32'h00000000;
        end else if (pw_wr && req.addr == PW_SCR_OFS + 8'(gi)) begin
          scr_r[gi] <= req.wdata;
        end
      end
    end
  endgenerate

  function automatic logic [31:0] pw_read(input logic [7:0] a);
    logic [7:0] i;
    i = 8'h00;
    pw_read = 32'h00000000;
    if (a == PW_ID_OFS) begin
      pw_read = {6'h00, CORE_NUM, NODE_IDENTIFIER, CORE_REV, CORE_VER};
    end else if (a == PW_RES1_OFS) begin
      pw_read = CORE_RES1;
    end else if (a == PW_RES2_OFS) begin
      pw_read = {16'h0000, CORE_RES2[15:0]};
    end else if (a == PW_PERM_OFS) begin
      pw_read = perm_r;
    end else if (a == PW_CLK_OFS) begin
      pw_read = {24'h000000, slow_r, 7'h00};
    end else if (a == PW_SEC_OFS) begin
      pw_read = SEC_CFG;
    end else if (in_blk(a, PW_PLINK_OFS, 4)) begin
      i = a - PW_PLINK_OFS;
      pw_read = PLINK_STAT[i[1:0]*32 +: 32];
    end else if (in_blk(a, PW_SCR_OFS, NSCR)) begin
      i = a - PW_SCR_OFS;
      pw_read = scr_r[i[2:0]];
    end else if (in_blk(a, PW_PC_OFS, NTHREAD)) begin
      i = a - PW_PC_OFS;
      pw_read = THREAD_PC[i[2:0]*32 +: 32];
    end else if (in_blk(a, PW_SR_OFS, NTHREAD)) begin
      i = a - PW_SR_OFS;
      pw_read = THREAD_SR[i[2:0]*32 +: 32];
    end else if (in_blk(a, PW_LOGICAL_LINK_OFS, 32)) begin
      i = a - PW_LOGICAL_LINK_OFS;
      pw_read = LOGICAL_LINK_STAT[i[4:0]*32 +: 32];
    end
  endfunction

  // ****************************************************
  // System switch bank
  // ****************************************************
  logic [31:0] ncfg_r;
  logic [31:0] node_r;
  logic [31:0] pll_r;
  logic [31:0] swdiv_r;
  logic [31:0] refdiv_r;
  logic [31:0] ext_r [NLINK];
  logic [31:0] int_r [NLINK];
  logic [31:0] spd_r [NLINK];
  logic ss_wr;

  assign ss_wr = req.valid && req.wr && req.bank == BANK_SS
    && !ncfg_r[NCFG_LOCK_BIT];

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ncfg_r <= 32'h00000000;
      node_r <= 32'h00000000;
      swdiv_r <= SWDIV_RST;
      refdiv_r <= REFDIV_RST;
    end else if (ss_wr) begin
      if (req.addr == SS_NCFG_OFS) begin
        ncfg_r <= req.wdata & NCFG_MASK;
      end else if (req.addr == SS_NODE_OFS) begin
        node_r <= req.wdata & NODE_MASK;
      end else if (req.addr == SS_SWDIV_OFS) begin
        swdiv_r <= req.wdata & DIV_MASK;
      end else if (req.addr == SS_REFDIV_OFS) begin
        refdiv_r <= req.wdata & DIV_MASK;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      pll_r <= PLL_RST;
    end else if (ss_wr && req.addr == SS_PLL_OFS
        && !ncfg_r[NCFG_PLLLOCK_BIT]) begin
      pll_r <= req.wdata & PLL_MASK;
    end
  end

  generate
    for (gi = 0; gi < NLINK; gi++) begin : g_link
      always_ff @(posedge CLK) begin
        if (!RSTN) begin
          ext_r[gi] <= 32'h00000000;
          int_r[gi] <= 32'h00000000;
          spd_r[gi] <= 32'h00000000;
        end else if (ss_wr) begin
          if (req.addr == SS_EXT_OFS + 8'(gi)) begin
            ext_r[gi] <= req.wdata & EXT_MASK;
          end else if (req.addr == SS_INT_OFS + 8'(gi)) begin
            int_r[gi] <= req.wdata & INT_MASK;
          end else if (req.addr == SS_SPD_OFS + 8'(gi)) begin
            spd_r[gi] <= req.wdata & SPD_MASK;
          end
        end
      end
      assign EXT_CFG[gi*32 +: 32] = ext_r[gi];
      assign INT_CFG[gi*32 +: 32] = int_r[gi];
      assign SPD_CFG[gi*32 +: 32] = spd_r[gi];
    end
  endgenerate

  function automatic logic [31:0] ss_read(input logic [7:0] a);
    logic [7:0] i;
    i = 8'h00;
    ss_read = 32'h00000000;
    if (a == SS_ID_OFS) begin
      ss_read = {6'h00, CORE_CFG, BOOT_CTRL, SW_REV, SW_VER};
    end else if (a == SS_RES_OFS) begin
      ss_read = {8'h00, SW_RES[23:0]};
    end else if (a == SS_NCFG_OFS) begin
      ss_read = ncfg_r;
    end else if (a == SS_NODE_OFS) begin
      ss_read = node_r;
    end else if (a == SS_PLL_OFS) begin
      ss_read = pll_r;
    end else if (a == SS_SWDIV_OFS) begin
      ss_read = swdiv_r;
    end else if (a == SS_REFDIV_OFS) begin
      ss_read = refdiv_r;
    end else if (in_blk(a, SS_EXT_OFS, NLINK)) begin
      i = a - SS_EXT_OFS;
      ss_read = ext_r[i[3:0]];
    end else if (in_blk(a, SS_INT_OFS, NLINK)) begin
      i = a - SS_INT_OFS;
      ss_read = int_r[i[3:0]];
    end else if (in_blk(a, SS_SPD_OFS, NLINK)) begin
      i = a - SS_SPD_OFS;
      ss_read = spd_r[i[3:0]];
    end
  endfunction

  // ****************************************************
  // Local read port and outputs
  // ****************************************************
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      LOC_RDATA <= 32'h00000000;
      LOC_ACK <= 1'b0;
    end else begin
      LOC_ACK <= LOC_REQ.valid;
      if (LOC_REQ.valid && !LOC_REQ.wr) begin
        LOC_RDATA <= (LOC_REQ.bank == BANK_SS) ? ss_read(LOC_REQ.addr)
          : (LOC_REQ.bank == BANK_PW) ? pw_read(LOC_REQ.addr) : 32'h0;
      end
    end
  end

  assign DBG_IRQ = dbg_irq_r;
  assign SLOW_MODE = slow_r;
  assign PROC_WR_DIS = perm_r[PERM_WRDIS_BIT];
  assign SHORT_HDR = ncfg_r[NCFG_SHORT_BIT];
  assign RAM_BASE = ram_base_r;
  assign VEC_BASE = vec_base_r;
  assign PLL_CTRL = pll_r;
  assign NODE_IDENTIFIER = node_r[7:0];
  assign SW_DIV = swdiv_r[7:0];
  assign REF_DIV = refdiv_r[7:0];

endmodule
`default_nettype wire

// ==== shared/csc_pkg.sv ====
// Purpose: constants and carrier types for the core and switch config regs
// Assumes: 32-bit registers, 8-bit register numbers
// Notes: switch bank offsets are register numbers as seen by config messages; status offsets come from PS_RESID[15:8]
package csc_pkg;
  // Processor status bank
  localparam logic [7:0] RAM_BASE_ADDRESS_OFS = 8'h00;
  localparam logic [7:0] PS_VEC_BASE_OFS = 8'h01;
  localparam logic [7:0] PS_RES_TYPE = 8'h0B;
  localparam logic [31:0] RAM_BASE_ADDRESS_RST = 32'h00010000;
  localparam logic [31:0] PS_VEC_MASK = 32'hFFFF0000;
  // Processor switch bank
  localparam logic [7:0] PW_ID_OFS = 8'h00;
  localparam logic [7:0] PW_RES1_OFS = 8'h01;
  localparam logic [7:0] PW_RES2_OFS = 8'h02;
  localparam logic [7:0] PW_PERM_OFS = 8'h04;
  localparam logic [7:0] PW_DBGINT_OFS = 8'h05;
  localparam logic [7:0] PW_CLK_OFS = 8'h06;
  localparam logic [7:0] PW_SEC_OFS = 8'h07;
  localparam logic [7:0] PW_PLINK_OFS = 8'h10;
  localparam logic [7:0] PW_SCR_OFS = 8'h20;
  localparam logic [7:0] PW_PC_OFS = 8'h40;
  localparam logic [7:0] PW_SR_OFS = 8'h60;
  localparam logic [7:0] PW_LOGICAL_LINK_OFS = 8'h80;
  localparam int PERM_WRDIS_BIT = 0;
  localparam int PERM_REMDIS_BIT = 8;
  localparam int PERM_LOCK_BIT = 31;
  localparam int DBGINT_BIT = 0;
  localparam int SLOW_BIT = 7;
  localparam logic [31:0] PERM_MASK = 32'h80000101;
  localparam logic [31:0] CLK_MASK = 32'h00000080;
  // System switch bank
  localparam logic [7:0] SS_ID_OFS = 8'h00;
  localparam logic [7:0] SS_RES_OFS = 8'h01;
  localparam logic [7:0] SS_NCFG_OFS = 8'h04;
  localparam logic [7:0] SS_NODE_OFS = 8'h05;
  localparam logic [7:0] SS_PLL_OFS = 8'h06;
  localparam logic [7:0] SS_SWDIV_OFS = 8'h07;
  localparam logic [7:0] SS_REFDIV_OFS = 8'h08;
  localparam logic [7:0] SS_EXT_OFS = 8'h20;
  localparam logic [7:0] SS_INT_OFS = 8'h40;
  localparam logic [7:0] SS_SPD_OFS = 8'h80;
  localparam int NCFG_SHORT_BIT = 0;
  localparam int NCFG_PLLLOCK_BIT = 8;
  localparam int NCFG_LOCK_BIT = 31;
  localparam logic [31:0] NCFG_MASK = 32'h80000101;
  localparam logic [31:0] NODE_MASK = 32'h000000FF;
  // PLL fields: N [4:0], M [15:8], P [23:16], band [24]
  localparam logic [31:0] PLL_MASK = 32'h01FFFF1F;
  localparam logic [31:0] PLL_RST = 32'h00000000;
  localparam logic [31:0] DIV_MASK = 32'h000000FF;
  localparam logic [31:0] SWDIV_RST = 32'h00000000;
  localparam logic [31:0] REFDIV_RST = 32'h00000002;
  localparam logic [31:0] EXT_MASK = 32'h00000730;
  localparam logic [31:0] INT_MASK = 32'h00000030;
  localparam logic [31:0] SPD_MASK = 32'hC0000F0F;
  // Message tokens
  localparam logic [7:0] TOK_CONFIG_WRITE_TOKEN = 8'hC0;
  localparam logic [7:0] TOK_ACK = 8'h03;
  localparam logic [7:0] TOK_EOM = 8'h01;

  typedef enum logic [1:0] {
    BANK_PS = 2'b00,
    BANK_PW = 2'b01,
    BANK_SS = 2'b11
  } csc_bank_t;

  // One register request
  typedef struct packed {
    logic valid;
    logic wr;
    logic remote;
    csc_bank_t bank;
    logic [7:0] addr;
    logic [31:0] wdata;
  } csc_req_t;

  // Message byte with control-token flag
  typedef struct packed {
    logic ctrl;
    logic [7:0] data;
  } csc_tok_t;
endpackage

// ==== testbench/csc_regs_assertions.sv ====
// Purpose: port checks for the config register banks
// Assumes: one clock, synchronous active-low reset
// Notes: bound to csc_regs
`timescale 1ns/1ps
`default_nettype none
module csc_regs_assertions
  import csc_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire csc_req_t LOC_REQ,
  input wire logic LOC_ACK,
  input wire csc_tok_t MSG_IN,
  input wire logic MSG_IN_VALID,
  input wire csc_tok_t MSG_OUT,
  input wire logic MSG_OUT_VALID,
  input wire logic MSG_OUT_READY,
  input wire logic DBG_IRQ,
  input wire logic SLOW_MODE,
  input wire logic [31:0] RAM_BASE,
  input wire logic [7:0] REF_DIV,
  input wire logic [7:0] NODE_IDENTIFIER
);
  // ********
  // Checks
  // ********
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  a_ack_follows: assert property (LOC_REQ.valid |=> LOC_ACK)
    else $error("ack missing after request");
  a_ack_only: assert property (!LOC_REQ.valid |=> !LOC_ACK)
    else $error("ack without request");
  a_reset_values: assert property ($rose(RSTN) |->
    RAM_BASE == RAM_BASE_ADDRESS_RST && REF_DIV == 8'h02 && !MSG_OUT_VALID)
    else $error("wrong value after reset");
  a_irq_cause: assert property (DBG_IRQ |-> $past(MSG_IN_VALID) ||
    $past(LOC_REQ.valid && LOC_REQ.wr && LOC_REQ.bank == BANK_PW &&
    LOC_REQ.addr == PW_DBGINT_OFS && LOC_REQ.wdata[0]))
    else $error("debug interrupt without a write of one");
  a_slow_cause: assert property ($changed(SLOW_MODE) |->
    $past(LOC_REQ.valid && LOC_REQ.wr) || $past(MSG_IN_VALID))
    else $error("slow mode changed without a write");
  a_node_value: assert property ($changed(NODE_IDENTIFIER) &&
    $past(LOC_REQ.valid) |-> NODE_IDENTIFIER == $past(LOC_REQ.wdata[7:0]) &&
    $past(LOC_REQ.addr) == SS_NODE_OFS)
    else $error("node_identifier not the written low byte");
  a_reply_first: assert property ($rose(MSG_OUT_VALID) |->
    MSG_OUT.ctrl && MSG_OUT.data == TOK_ACK && $past(MSG_IN_VALID &&
    MSG_IN.ctrl && MSG_IN.data == TOK_EOM))
    else $error("reply not an ack after end token");
  a_reply_eom: assert property (MSG_OUT_VALID && MSG_OUT_READY &&
    MSG_OUT.data == TOK_ACK |=> MSG_OUT_VALID && MSG_OUT.ctrl &&
    MSG_OUT.data == TOK_EOM)
    else $error("end token does not follow ack");
  a_reply_hold: assert property (MSG_OUT_VALID && !MSG_OUT_READY
    |=> MSG_OUT_VALID && $stable(MSG_OUT))
    else $error("reply byte dropped while stalled");
  a_reply_done: assert property (MSG_OUT_VALID && MSG_OUT_READY &&
    MSG_OUT.data == TOK_EOM |=> !MSG_OUT_VALID)
    else $error("reply runs past end token");
endmodule
bind csc_regs csc_regs_assertions u_chk (
  .CLK(CLK), .RSTN(RSTN), .LOC_REQ(LOC_REQ), .LOC_ACK(LOC_ACK),
  .MSG_IN(MSG_IN), .MSG_IN_VALID(MSG_IN_VALID), .MSG_OUT(MSG_OUT),
  .MSG_OUT_VALID(MSG_OUT_VALID), .MSG_OUT_READY(MSG_OUT_READY),
  .DBG_IRQ(DBG_IRQ), .SLOW_MODE(SLOW_MODE), .RAM_BASE(RAM_BASE),
  .REF_DIV(REF_DIV), .NODE_IDENTIFIER(NODE_IDENTIFIER)
);
`default_nettype wire

// ==== testbench/csc_msg_host.sv ====
// Purpose: remote sender of config write messages
// Assumes: caller enters tasks just after a rising edge
// Notes: reply bytes land in rx_q; ready stalls at random
`timescale 1ns/1ps
`default_nettype none
module csc_msg_host
  import csc_pkg::*;
(
  input wire logic clk,
  output var csc_tok_t msg_in,
  output var logic msg_in_valid,
  output var logic msg_bank_ss,
  input wire csc_tok_t msg_out,
  input wire logic msg_out_valid,
  output var logic msg_out_ready
);
  csc_tok_t rx_q[$];
  initial begin
    msg_in = '0;
    msg_in_valid = 1'b0;
    msg_bank_ss = 1'b0;
    msg_out_ready = 1'b0;
  end
  always @(posedge clk) msg_out_ready <= $urandom_range(2) != 0;
  always @(posedge clk) if (msg_out_valid && msg_out_ready) begin
    rx_q.push_back(msg_out);
  end
  task automatic put(bit c, logic [7:0] v);
    msg_in <= '{c, v};
    msg_in_valid <= 1'b1;
    @(posedge clk);
  endtask
  task automatic send(bit ss, logic [15:0] a, logic [31:0] d,
      logic [7:0] f);
    msg_bank_ss <= ss;
    put(1'b1, TOK_CONFIG_WRITE_TOKEN);
    for (int i = 0; i < 3; i++) put(1'b0, 8'h40 + 8'(i));
    put(1'b0, a[15:8]);
    put(1'b0, a[7:0]);
    for (int i = 3; i >= 0; i--) put(1'b0, d[i * 8 +: 8]);
    put(1'b1, f);
    // Released lines show the inverse
    msg_in_valid <= 1'b0;
    msg_in <= ~msg_in;
    msg_bank_ss <= ~ss;
  endtask
endmodule
`default_nettype wire

// ==== testbench/test_core_and_switch_config_regs.sv ====
// Purpose: self-checking bench for the config register banks
// Assumes: default thread and link counts
// Notes: identity and resource values are arbitrary
`timescale 1ns/1ps
`default_nettype none
module test_core_and_switch_config_regs
  import csc_pkg::*;
;
  // Arbitrary identity and resource values
  localparam logic [7:0] CVER = 8'h3A, CREV = 8'h05;
  localparam logic [7:0] SWVER = 8'h2B, SWREV = 8'h07;
  localparam logic [1:0] CNUM = 2'h2;
  localparam logic [31:0] RES1 = 32'h10200408, RES2 = 32'h00000302;
  localparam logic [31:0] SWRES = 32'h00140302;
  logic clk, rstn, ps_valid, ps_wr, loc_ack, msg_bank_ss, irq_s;
  logic msg_in_valid, msg_out_valid, msg_out_ready, dbg_irq, slow;
  logic wrdis, short_hdr;
  csc_req_t loc_req;
  csc_tok_t msg_in, msg_out;
  logic [31:0] loc_rdata, ps_resid, ps_wdata, ps_rdata, sec, ram, vec;
  logic [31:0] pll;
  logic [511:0] ecfg, icfg, scfg;
  logic [7:0] boot, node_identifier, sw_div, ref_div;
  logic [1:0] ccfg;
  logic [255:0] pc, sr;
  logic [127:0] pl;
  logic [1023:0] ll;
  logic [31:0] mpw [256], mss [256];
  int fails, n_compared, cyc;
  csc_regs #(.CORE_VER(CVER), .CORE_REV(CREV), .CORE_NUM(CNUM),
    .CORE_RES1(RES1), .CORE_RES2(RES2), .SW_VER(SWVER),
    .SW_REV(SWREV), .SW_RES(SWRES)) dut (
    .CLK(clk), .RSTN(rstn), .LOC_REQ(loc_req), .LOC_RDATA(loc_rdata),
    .LOC_ACK(loc_ack), .PS_VALID(ps_valid), .PS_WR(ps_wr),
    .PS_RESID(ps_resid), .PS_WDATA(ps_wdata), .PS_RDATA(ps_rdata),
    .MSG_IN(msg_in), .MSG_IN_VALID(msg_in_valid), .MSG_OUT(msg_out),
    .MSG_OUT_VALID(msg_out_valid), .MSG_OUT_READY(msg_out_ready),
    .MSG_BANK_SS(msg_bank_ss), .THREAD_PC(pc), .THREAD_SR(sr),
    .PLINK_STAT(pl), .LOGICAL_LINK_STAT(ll), .SEC_CFG(sec), .BOOT_CTRL(boot),
    .CORE_CFG(ccfg), .DBG_IRQ(dbg_irq), .SLOW_MODE(slow),
    .PROC_WR_DIS(wrdis), .SHORT_HDR(short_hdr), .RAM_BASE(ram),
    .VEC_BASE(vec), .PLL_CTRL(pll), .NODE_IDENTIFIER(node_identifier), .SW_DIV(sw_div),
    .REF_DIV(ref_div), .EXT_CFG(ecfg), .INT_CFG(icfg), .SPD_CFG(scfg));
  csc_msg_host h (.clk(clk), .msg_in(msg_in), .msg_in_valid(msg_in_valid),
    .msg_bank_ss(msg_bank_ss), .msg_out(msg_out),
    .msg_out_valid(msg_out_valid), .msg_out_ready(msg_out_ready));
  // ********
  // Model
  // ********
  function automatic logic [31:0] msk(bit ss, int a);
    if (!ss) return a == 4 ? PERM_MASK : a == 6 ? CLK_MASK :
      a >> 3 == 4 ? 32'hFFFFFFFF : 32'h0;
    return a == 4 ? NCFG_MASK : a == 5 ? NODE_MASK : a == 6 ? PLL_MASK :
      a == 7 || a == 8 ? DIV_MASK : a >> 4 == 2 ? EXT_MASK :
      a >> 4 == 4 ? INT_MASK : a >> 4 == 8 ? SPD_MASK : 32'h0;
  endfunction
  function automatic void mwr(bit ss, int a, logic [31:0] d, bit rem);
    if (ss && (mss[4][31] || (a == 6 && mss[4][8]))) return;
    if (!ss && (mpw[4][31] || (rem && mpw[4][8]))) return;
    if (ss) mss[a] = d & msk(1, a);
    else mpw[a] = d & msk(0, a);
  endfunction
  function automatic logic [31:0] exp_rd(bit ss, int a);
    if (ss) return a == 0 ? {6'h0, ccfg, boot, SWREV, SWVER} :
      a == 1 ? SWRES : mss[a];
    if (a == 0) return {6'h0, CNUM, mss[5][7:0], CREV, CVER};
    if (a == 1) return RES1;
    if (a == 2) return RES2;
    if (a == 7) return sec;
    if (a >> 2 == 4) return pl[a % 4 * 32 +: 32];
    if (a >> 3 == 8) return pc[a % 8 * 32 +: 32];
    if (a >> 3 == 12) return sr[a % 8 * 32 +: 32];
    if (a >> 5 == 4) return ll[a % 32 * 32 +: 32];
    return mpw[a];
  endfunction
  // ********
  // Tasks
  // ********
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim();
    if (fails == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic acc(bit ss, int a, logic [31:0] d, bit w, bit rem);
    loc_req <= '{1'b1, w, rem, ss ? BANK_SS : BANK_PW, a[7:0], d};
    @(posedge clk);
    loc_req.valid <= 1'b0;
    #1;
    irq_s = dbg_irq;
    chk("ack", 1, {31'h0, loc_ack});
    if (!w) chk($sformatf("reg %0d %h", ss, a), exp_rd(ss, a), loc_rdata);
    @(posedge clk);
  endtask
  task automatic wr(bit ss, int a, logic [31:0] d, bit rem);
    acc(ss, a, d, 1'b1, rem);
    mwr(ss, a, d, rem);
  endtask
  task automatic ps(bit w, logic [7:0] n, logic [31:0] d);
    ps_valid <= 1'b1;
    ps_wr <= w;
    ps_resid <= {16'h0, n, PS_RES_TYPE};
    ps_wdata <= d;
    @(posedge clk);
    ps_valid <= 1'b0;
    #1;
    if (!w) chk("status", d, ps_rdata);
    @(posedge clk);
  endtask
  task automatic msg(bit ss, logic [15:0] a, logic [31:0] d,
      logic [7:0] f, bit rep);
    h.send(ss, a, d, f);
    if (f == TOK_EOM && a[15:8] == 8'h0) mwr(ss, a[7:0], d, 1'b1);
    for (int i = 0; i < 40 && h.rx_q.size() < 2; i++) @(posedge clk);
    if (f != TOK_EOM) chk("noreply", 0, h.rx_q.size());
    else if (rep) begin
      chk("replies", 2, h.rx_q.size());
      chk("ack", {23'h0, 1'b1, TOK_ACK}, {23'h0, h.rx_q[0]});
      chk("eom", {23'h0, 1'b1, TOK_EOM}, {23'h0, h.rx_q[1]});
    end
    h.rx_q.delete();
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end
  // ********
  // Scenarios
  // ********
  initial begin
    logic [31:0] d;
    void'($urandom(32'hA037));
    rstn = 1'b0;
    loc_req = '0;
    ps_valid = 1'b0;
    ps_wr = 1'b0;
    ps_resid = '0;
    ps_wdata = '0;
    for (int i = 0; i < 256; i++) begin
      mpw[i] = '0;
      mss[i] = '0;
      if (i < 32) ll[i * 32 +: 32] = $urandom;
      if (i < 8) pc[i * 32 +: 32] = $urandom;
      if (i < 8) sr[i * 32 +: 32] = $urandom;
      if (i < 4) pl[i * 32 +: 32] = $urandom;
    end
    mss[8] = 32'h2;
    sec = $urandom;
    {boot, ccfg} = 10'($urandom);
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk("ram", RAM_BASE_ADDRESS_RST, ram);
    chk("refdiv", 32'h2, {24'h0, ref_div});
    ps(1'b1, PS_VEC_BASE_OFS, 32'hABCD0000);
    ps(1'b0, PS_VEC_BASE_OFS, 32'hABCD0000);
    chk("vec", 32'hABCD0000, vec);
    ps(1'b0, RAM_BASE_ADDRESS_OFS, RAM_BASE_ADDRESS_RST);
    for (int a = 0; a < 256; a++) begin
      for (int b = 0; b < 2; b++) begin
        d = $urandom;
        if (a != 4) begin
          wr(b[0], a, d, 1'b0);
          chk("irq", {31'h0, b == 0 && a == 5 && d[0]}, {31'h0, irq_s});
          acc(b[0], a, d, 1'b0, 1'b0);
        end
      end
      chk("slow", {31'h0, mpw[6][7]}, {31'h0, slow});
      chk("node", mss[5] & NODE_MASK, {24'h0, node_identifier});
      chk("pll", mss[6], pll);
      chk("swdiv", mss[7], {24'h0, sw_div});
    end
    for (int i = 0; i < 16; i++) begin
      chk("ext", mss[32 + i], ecfg[i * 32 +: 32]);
      chk("int", mss[64 + i], icfg[i * 32 +: 32]);
      chk("spd", mss[128 + i], scfg[i * 32 +: 32]);
    end
    wr(1'b0, PW_PERM_OFS, 32'h1, 1'b0);
    chk("wrdis", 1, {31'h0, wrdis});
    wr(1'b0, PW_PERM_OFS, 32'h100, 1'b0);
    msg(1'b0, 16'h0021, 32'h13572468, TOK_EOM, 1'b0);
    acc(1'b0, 8'h21, 0, 1'b0, 1'b0);
    wr(1'b0, PW_PERM_OFS, 32'h0, 1'b1);
    acc(1'b0, PW_PERM_OFS, 0, 1'b0, 1'b0);
    wr(1'b0, PW_PERM_OFS, 32'h0, 1'b0);
    msg(1'b0, 16'h0022, 32'hC0FFEE11, TOK_EOM, 1'b1);
    msg(1'b0, 16'h0122, 32'h0, TOK_EOM, 1'b1);
    msg(1'b0, 16'h0022, 32'h0, 8'h02, 1'b1);
    acc(1'b0, 8'h22, 0, 1'b0, 1'b0);
    msg(1'b1, 16'h0005, 32'hFFFFFF3C, TOK_EOM, 1'b1);
    acc(1'b0, PW_ID_OFS, 0, 1'b0, 1'b0);
    wr(1'b1, SS_NCFG_OFS, 32'h101, 1'b0);
    chk("short", 1, {31'h0, short_hdr});
    wr(1'b1, SS_PLL_OFS, $urandom, 1'b0);
    acc(1'b1, SS_PLL_OFS, 0, 1'b0, 1'b0);
    wr(1'b1, SS_NCFG_OFS, 32'h80000000, 1'b0);
    wr(1'b1, SS_SWDIV_OFS, 32'h5, 1'b0);
    acc(1'b1, SS_SWDIV_OFS, 0, 1'b0, 1'b0);
    acc(1'b1, SS_NCFG_OFS, 0, 1'b0, 1'b0);
    wr(1'b0, PW_PERM_OFS, 32'h80000000, 1'b0);
    wr(1'b0, 8'h23, 32'h5A5A0F0F, 1'b0);
    acc(1'b0, 8'h23, 0, 1'b0, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
